// ===== ctu_pkg.sv
// Package of constants and types for the charge time unit control block
package ctu_pkg;
	localparam logic [1:0] CTU_ADDR_CONTROL_HIGH = 2'h0;
	localparam logic [1:0] CTU_ADDR_CONTROL_LOW = 2'h1;
	localparam logic [1:0] CTU_ADDR_CURRENT = 2'h2;
	localparam logic [7:0] CTU_RESET_VALUE = 8'h00;
	localparam logic [7:0] CTU_HIGH_MASK = 8'hbf;
	localparam int CTU_POS_ENABLE = 7;
	localparam int CTU_POS_STOP_IDLE = 5;
	localparam int CTU_POS_DELAY_GEN = 4;
	localparam int CTU_POS_EDGE_PASS = 3;
	localparam int CTU_POS_ORDERING = 2;
	localparam int CTU_POS_GROUND = 1;
	localparam int CTU_POS_TRIGGER = 0;
	localparam int CTU_POS_SECOND_SEEN = 1;
	localparam int CTU_POS_FIRST_SEEN = 0;

	typedef enum logic [1:0] {
		CTU_SRC_COMPARE_TWO = 2'b00,
		CTU_SRC_COMPARE_ONE = 2'b01,
		CTU_SRC_PIN_TWO = 2'b10,
		CTU_SRC_PIN_ONE = 2'b11
	} ctu_source_type;

	typedef enum logic [1:0] {
		CTU_RANGE_OFF = 2'b00,
		CTU_RANGE_BASE = 2'b01,
		CTU_RANGE_TEN = 2'b10,
		CTU_RANGE_HUNDRED = 2'b11
	} ctu_range_type;

	typedef struct packed {
		logic unit_enable;
		logic unused_six;
		logic stop_in_idle;
		logic delay_generation_enable;
		logic edge_pass_enable;
		logic edge_ordering_enable;
		logic source_ground_control;
		logic converter_trigger_enable;
	} ctu_high_type;

	typedef struct packed {
		logic second_edge_polarity;
		ctu_source_type second_edge_source;
		logic first_edge_polarity;
		ctu_source_type first_edge_source;
		logic second_edge_seen;
		logic first_edge_seen;
	} ctu_low_type;

	typedef struct packed {
		logic [5:0] current_trim;
		ctu_range_type current_range;
	} ctu_current_type;

	// Analog-side controls, all registered
	typedef struct packed {
		logic charge_on;
		logic ground_on;
		ctu_range_type range;
		logic [5:0] trim;
		logic pulse;
		logic converter_trigger;
	} ctu_analog_type;

	// Edge sources: pins and compare-unit triggers
	typedef struct packed {
		logic pin_one;
		logic pin_two;
		logic compare_one;
		logic compare_two;
	} ctu_sources_type;

	typedef struct packed {
		ctu_high_type high;
		ctu_low_type low;
		ctu_current_type current;
		ctu_sources_type sync_a;
		ctu_sources_type sync_b;
		ctu_sources_type prev;
		logic cmp_a;
		logic cmp_b;
		logic cmp_prev;
		logic [7:0] rdata;
		ctu_analog_type analog;
	} ctu_state_type;
endpackage

// ===== ctu_charge_time_unit.sv
// Control logic of the charge time unit: registers, edge detection, analog controls
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module ctu_charge_time_unit
	import ctu_pkg::*;
(
	// Clock, reset, clock gate
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic unit_clock_gate_in,
	// Register port
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [7:0] rdata_out,
	// Power modes
	input wire logic idle_mode_in,
	input wire logic sleep_mode_in,
	// Edge sources and trip comparator, all asynchronous
	input wire logic edge_pin_one_in,
	input wire logic edge_pin_two_in,
	input wire logic compare_unit_one_in,
	input wire logic compare_unit_two_in,
	input wire logic trip_comparator_in,
	// Analog controls
	output logic charge_on_out,
	output logic ground_on_out,
	output logic [1:0] current_range_out,
	output logic [5:0] current_trim_out,
	output logic delay_pulse_output_out,
	output logic converter_trigger_out
);
	ctu_state_type state;
	ctu_state_type next_state;
	logic unit_clock;

	// Select a source's current and previous level by code
	function automatic logic pick(input ctu_source_type sel, input ctu_sources_type s);
		logic value;
		value = 1'b0;
		unique case (sel)
			CTU_SRC_PIN_ONE: value = s.pin_one;
			CTU_SRC_PIN_TWO: value = s.pin_two;
			CTU_SRC_COMPARE_ONE: value = s.compare_one;
			CTU_SRC_COMPARE_TWO: value = s.compare_two;
		endcase
		return value;
	endfunction

	// Edge of chosen polarity between previous and current level
	function automatic logic edge_hit(input logic pol, input logic prev, input logic now);
		return pol ? (now && !prev) : (!now && prev);
	endfunction

	// Clock gate: latch-based, enable changes only while clock is low
	logic gate_open_n;
	always_latch begin
		if (!clk_sys_in) begin
			gate_open_n = unit_clock_gate_in;
		end
	end
	assign unit_clock = clk_sys_in && !gate_open_n;

	always_comb begin
		logic running;
		logic hit_first;
		logic hit_second;
		logic set_first;
		logic set_second;
		logic source_live;
		running = 1'b0;
		hit_first = 1'b0;
		hit_second = 1'b0;
		set_first = 1'b0;
		set_second = 1'b0;
		source_live = 1'b0;
		next_state = state;

		next_state.sync_a.pin_one = edge_pin_one_in;
		next_state.sync_a.pin_two = edge_pin_two_in;
		next_state.sync_a.compare_one = compare_unit_one_in;
		next_state.sync_a.compare_two = compare_unit_two_in;
		next_state.sync_b = state.sync_a;
		next_state.prev = state.sync_b;
		next_state.cmp_a = trip_comparator_in;
		next_state.cmp_b = state.cmp_a;
		next_state.cmp_prev = state.cmp_b;

		// Unit halts in Idle only when asked to
		running = state.high.unit_enable && !(idle_mode_in && state.high.stop_in_idle);

		hit_first = edge_hit(state.low.first_edge_polarity, pick(state.low.first_edge_source, state.prev),
			pick(state.low.first_edge_source, state.sync_b));
		hit_second = edge_hit(state.low.second_edge_polarity, pick(state.low.second_edge_source, state.prev),
			pick(state.low.second_edge_source, state.sync_b));
		set_first = running && state.high.edge_pass_enable && hit_first;
		set_second = running && state.high.edge_pass_enable && hit_second
			&& (!state.high.edge_ordering_enable || state.low.first_edge_seen);

		next_state.rdata = 8'h00;
		if (read_in) begin
			unique case (addr_in)
				CTU_ADDR_CONTROL_HIGH: next_state.rdata = state.high & CTU_HIGH_MASK;
				CTU_ADDR_CONTROL_LOW: next_state.rdata = state.low;
				CTU_ADDR_CURRENT: next_state.rdata = state.current;
				default: next_state.rdata = 8'h00;
			endcase
		end

		if (write_in) begin
			unique case (addr_in)
				CTU_ADDR_CONTROL_HIGH: next_state.high = ctu_high_type'(wdata_in & CTU_HIGH_MASK);
				CTU_ADDR_CONTROL_LOW: next_state.low = ctu_low_type'(wdata_in);
				CTU_ADDR_CURRENT: next_state.current = ctu_current_type'(wdata_in);
				default: ;
			endcase
		end
		// Hardware set wins over a same-cycle software clear
		if (set_first) begin
			next_state.low.first_edge_seen = 1'b1;
		end
		if (set_second) begin
			next_state.low.second_edge_seen = 1'b1;
		end

		// Source live only when enabled, ranged, awake and not idled
		source_live = running && !sleep_mode_in && (state.current.current_range != CTU_RANGE_OFF);
		next_state.analog.charge_on = source_live && state.low.first_edge_seen
			&& !state.low.second_edge_seen;
		next_state.analog.ground_on = state.high.source_ground_control;
		next_state.analog.range = source_live ? state.current.current_range : CTU_RANGE_OFF;
		next_state.analog.trim = state.current.current_trim;
		// Pulse in delay mode once the first edge is recorded and the trip point is reached
		next_state.analog.pulse = running && state.high.delay_generation_enable
			&& state.low.first_edge_seen && state.cmp_b;
		// Trigger pulse on the second edge being recorded
		next_state.analog.converter_trigger = state.high.converter_trigger_enable && set_second;
	end

	always_ff @(posedge unit_clock) begin
		if (!rstn_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata_out = state.rdata;
	assign charge_on_out = state.analog.charge_on;
	assign ground_on_out = state.analog.ground_on;
	assign current_range_out = state.analog.range;
	assign current_trim_out = state.analog.trim;
	assign delay_pulse_output_out = state.analog.pulse;
	assign converter_trigger_out = state.analog.converter_trigger;
endmodule

`default_nettype wire

// ===== ctu_props.sv
// Port checks for the charge time unit control block
`timescale 1ns/1ns
`default_nettype none
module ctu_props
	import ctu_pkg::*;
(
	// Clock, reset, gate
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic unit_clock_gate_in,
	// Register port, power mode
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic sleep_mode_in,
	// Outputs
	input wire logic [7:0] rdata_out,
	input wire logic charge_on_out,
	input wire logic ground_on_out,
	input wire logic [1:0] current_range_out,
	input wire logic [5:0] current_trim_out,
	input wire logic converter_trigger_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	// Gated cycles freeze state, so timing checks pause
	default disable iff (!rstn_in || unit_clock_gate_in);
	property p_range_off; current_range_out == 2'h0 |-> !charge_on_out; endproperty
	a_range_off: assert property (p_range_off) else $error("charge with range off");
	property p_sleep; sleep_mode_in [*3] |-> !charge_on_out; endproperty
	a_sleep: assert property (p_sleep) else $error("charge in sleep");
	property p_trig; converter_trigger_out |=> !converter_trigger_out; endproperty
	a_trig: assert property (p_trig) else $error("trigger too long");
	property p_trim; write_in && addr_in == CTU_ADDR_CURRENT ##1 !write_in [*2]
		|-> {current_trim_out, 2'h0} == ($past(wdata_in, 2) & 8'hfc); endproperty
	a_trim: assert property (p_trim) else $error("trim not written");
	property p_range_wr; write_in && addr_in == CTU_ADDR_CURRENT && wdata_in[1:0] == 2'h0
		|=> ##1 current_range_out == 2'h0; endproperty
	a_range_wr: assert property (p_range_wr) else $error("range not off");
	property p_ground; write_in && addr_in == CTU_ADDR_CONTROL_HIGH && wdata_in[1] |-> ##[1:2] ground_on_out; endproperty
	a_ground: assert property (p_ground) else $error("no grounding");
	property p_reset; disable iff (unit_clock_gate_in) !rstn_in
		|=> !charge_on_out && current_range_out == 2'h0 && rdata_out == 8'h00; endproperty
	a_reset: assert property (p_reset) else $error("reset not clean");
	property p_gate; disable iff (!rstn_in) unit_clock_gate_in [*2]
		|-> $stable(current_trim_out) && $stable(charge_on_out) && $stable(rdata_out); endproperty
	a_gate: assert property (p_gate) else $error("state moved while gated");
endmodule
bind ctu_charge_time_unit ctu_props u_props (.*);
`default_nettype wire

// ===== ctu_cap_model.sv
// Measured node model: charges while the source runs, trips at a level
`timescale 1ns/1ns
`default_nettype none
module ctu_cap_model #(parameter int TRIP_LEVEL = 4) (
	// Clock and analog controls
	input wire logic clk_sys_in,
	input wire logic charge_on_in,
	input wire logic ground_on_in,
	// Comparator
	output logic trip_out
);
	int level = 0;
	always @(posedge clk_sys_in) begin
		if (ground_on_in) begin
			level <= 0;
		end else if (charge_on_in) begin
			level <= level + 1;
		end
	end
	assign trip_out = level >= TRIP_LEVEL;
endmodule
`default_nettype wire

// ===== charge_time_measure_ctrl_tb.sv
// Self-checking bench for the charge time unit control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; $display("wrong value %0t %h %h", $time, a, e); end end
module charge_time_measure_ctrl_tb;
	import ctu_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic gate = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic idle = 1'b0;
	logic slp = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic [3:0] src = 4'h0;
	logic [7:0] rdata, rv;
	logic chg, gnd, pls, trg, trip;
	logic [1:0] rng;
	logic [5:0] trim;
	int err_count = 0;
	int check_count = 0;
	int trg_count = 0;
	always #50 clk_sys_in = ~clk_sys_in;
	always @(negedge clk_sys_in) trg_count += trg;
	ctu_charge_time_unit u_dut (.clk_sys_in, .rstn_in, .unit_clock_gate_in(gate), .addr_in(addr),
		.wdata_in(wdata), .write_in(wr), .read_in(rd), .rdata_out(rdata), .idle_mode_in(idle),
		.sleep_mode_in(slp), .edge_pin_one_in(src[3]), .edge_pin_two_in(src[2]), .compare_unit_one_in(src[1]),
		.compare_unit_two_in(src[0]), .trip_comparator_in(trip), .charge_on_out(chg), .ground_on_out(gnd),
		.current_range_out(rng), .current_trim_out(trim), .delay_pulse_output_out(pls), .converter_trigger_out(trg));
	ctu_cap_model u_cap (.clk_sys_in, .charge_on_in(chg), .ground_on_in(gnd), .trip_out(trip));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
		// Step off the edge so a following write never reassigns the strobe in this time step
		#1;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		@(negedge clk_sys_in);
		d = rdata;
		cyc(1);
	endtask
	task automatic edge_chk(input int c, input logic v, input logic [1:0] e);
		src[c] <= v;
		cyc(5);
		rd_reg(CTU_ADDR_CONTROL_LOW, rv);
		`CHK(rv[1:0], e)
	endtask
	task automatic t_regs;
		for (int a = 0; a < 4; a++) begin
			rd_reg(a[1:0], rv);
			`CHK(rv, CTU_RESET_VALUE)
			wr_reg(a[1:0], 8'hff);
			rd_reg(a[1:0], rv);
			`CHK(rv, (a == 0) ? CTU_HIGH_MASK : (a == 3) ? 8'h00 : 8'hff)
		end
		for (int a = 0; a < 3; a++) begin
			wr_reg(a[1:0], 8'h00);
			rd_reg(a[1:0], rv);
			`CHK(rv, 8'h00)
		end
		$display("done registers");
	endtask
	task automatic t_edges;
		int n;
		wr_reg(CTU_ADDR_CURRENT, 8'h02);
		wr_reg(CTU_ADDR_CONTROL_HIGH, 8'h8b);
		wr_reg(CTU_ADDR_CONTROL_HIGH, 8'h89);
		for (int c = 0; c < 4; c++) begin
			for (int p = 0; p < 4; p++) begin
				wr_reg(CTU_ADDR_CONTROL_LOW, {~p[1], c[1:0], p[1], c[1:0], 2'b00});
				n = trg_count;
				edge_chk(c, ~src[c], (src[c] == p[1]) ? 2'b10 : 2'b01);
				`CHK(chg, src[c] == p[1])
				`CHK(trg_count - n, (src[c] == p[1]) ? 0 : 1)
			end
		end
		$display("done edges");
	endtask
	task automatic t_order;
		wr_reg(CTU_ADDR_CONTROL_HIGH, 8'h8c);
		wr_reg(CTU_ADDR_CONTROL_LOW, 8'hdc);
		edge_chk(2, 1'b1, 2'b00);
		edge_chk(3, 1'b1, 2'b01);
		wr_reg(CTU_ADDR_CONTROL_HIGH, 8'h80);
		wr_reg(CTU_ADDR_CONTROL_LOW, 8'hcc);
		edge_chk(3, 1'b0, 2'b00);
		$display("done ordering");
	endtask
	task automatic t_power;
		wr_reg(CTU_ADDR_CURRENT, 8'h01);
		wr_reg(CTU_ADDR_CONTROL_HIGH, 8'hb8);
		wr_reg(CTU_ADDR_CONTROL_LOW, 8'h01);
		cyc(12);
		`CHK(pls, 1'b1)
		idle <= 1'b1;
		cyc(3);
		`CHK(chg, 1'b0)
		idle <= 1'b0;
		slp <= 1'b1;
		cyc(3);
		`CHK(chg, 1'b0)
		slp <= 1'b0;
		wr_reg(CTU_ADDR_CONTROL_HIGH, 8'hba);
		cyc(2);
		`CHK(gnd, 1'b1)
		wr_reg(CTU_ADDR_CONTROL_HIGH, 8'hb8);
		cyc(2);
		`CHK(chg, 1'b1)
		rstn_in <= 1'b0;
		cyc(2);
		rstn_in <= 1'b1;
		cyc(1);
		`CHK(chg, 1'b0)
		gate <= 1'b1;
		cyc(2);
		wr_reg(CTU_ADDR_CURRENT, 8'hfc);
		// Gate held one more edge so the gated write is fully out of the trim check
		cyc(1);
		gate <= 1'b0;
		rd_reg(CTU_ADDR_CURRENT, rv);
		`CHK(rv, 8'h00)
		$display("done power");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		cyc(1);
		t_regs();
		t_edges();
		t_order();
		t_power();
		finish_test();
	end
	// Whole run is near 230 cycles
	initial begin
		#1000000;
		err_count++;
		finish_test();
	end
endmodule
`default_nettype wire
